// ==== rtl/ssp_pkg.sv ====
/*
 package for the synchronous slave serial port: register offsets, field
 positions, reset values, link states and carrier structs.
 assumes a plain register port with one-cycle strobes and an 8-bit data path.
*/
package ssp_pkg;
	// ==========================================
	// register offsets
	localparam logic [3:0] OFF_TX_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] OFF_RX_STATUS_CONTROL = 4'h1;
	localparam logic [3:0] OFF_TX_HOLDING_REGISTER = 4'h2;
	localparam logic [3:0] OFF_RX_DATA_BUFFER = 4'h3;
	localparam logic [3:0] OFF_PERIPHERAL_IRQ_ENABLE_ONE = 4'h4;
	localparam logic [3:0] OFF_PERIPHERAL_IRQ_FLAG_ONE = 4'h5;
	localparam logic [3:0] OFF_BAUD_DIVISOR_LOW = 4'h6;
	localparam logic [3:0] OFF_BAUD_DIVISOR_HIGH = 4'h7;
	localparam logic [3:0] OFF_BAUD_CONTROL_FIRST = 4'h8;
	localparam logic [3:0] OFF_CORE_IRQ_CONTROL = 4'h9;
	localparam logic [3:0] OFF_SLEEP_CONTROL = 4'ha;

	// ==========================================
	// field positions, tx_status_control
	localparam int TX_CLOCK_SOURCE_BIT = 7;
	localparam int TX_NINE_BIT = 6;
	localparam int TX_ENABLE_BIT = 5;
	localparam int TX_SYNC_BIT = 4;
	localparam int TX_SHIFT_EMPTY_BIT = 1;
	localparam int TX_NINTH_DATA_BIT = 0;
	// rx_status_control
	localparam int RX_PORT_ENABLE_BIT = 7;
	localparam int RX_NINE_BIT = 6;
	localparam int RX_SINGLE_BIT = 5;
	localparam int RX_CONT_BIT = 4;
	localparam int RX_FRAMING_BIT = 2;
	localparam int RX_OVERRUN_BIT = 1;
	localparam int RX_NINTH_DATA_BIT = 0;
	// peripheral enable and flag
	localparam int PI_RECEIVE_BIT = 5;
	localparam int PI_TRANSMIT_BIT = 4;
	// core irq control
	localparam int CORE_GLOBAL_BIT = 7;
	localparam int CORE_PERIPH_BIT = 6;
	// baud control
	localparam int BAUD_RX_IDLE_BIT = 6;

	// ==========================================
	// reset values and sizes
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [8:0] CHAR_ZERO = 9'h000;
	localparam logic [3:0] COUNT_ZERO = 4'h0;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;

	// link clock in the bench: 160 ns, core clock 20 ns
	localparam int LINK_PERIOD_NS = 160;
	localparam int CORE_PERIOD_NS = 20;
	localparam int LINK_CYCLES = LINK_PERIOD_NS / CORE_PERIOD_NS;

	// ==========================================
	// register bus carrier
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ssp_bus_t;

	// configuration seen by the shifter
	typedef struct packed {
		logic port_enable;
		logic sync_select;
		logic clock_source_master_select;
		logic transmit_enable;
		logic transmit_nine_bit_select;
		logic receive_nine_bit_select;
		logic continuous_receive_enable;
		logic single_receive_enable;
	} ssp_cfg_t;

	typedef enum logic [1:0] {
		SSP_IDLE,
		SSP_TX,
		SSP_RX
	} ssp_link_t;
endpackage

// ==== rtl/ssp_port.sv ====
/*
 synchronous slave serial port: register file, transmit holding and shift
 control, two-entry receive buffer, overrun, and wake and interrupt outputs.
 assumes an external master drives the clock line; sleep comes from the core.
*/
// What this block does
// - clock source clear selects slave operation
// - both receive enables clear means transmit
// - sync select and port enable activate port
// - slave transmit mirrors master, external clock
// - second word held, transmit flag stays clear
// - move held word, then set transmit flag
// - transmit flag wakes core, vectors if global
// - receive flag on full character, gated irq
// - overrun cleared by continuous or port enable
// - slave receives only with continuous enable, single enable alone receives nothing
// - continuous receive works during sleep
// - received character wakes core from sleep
// - external clock, change lead, sample trail
// - two-entry receive buffer, flag while unread
// - third character sets overrun, keeps data
`timescale 1ns/1ps
module ssp_port (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic core_sleep,
	input wire logic clock_line_pin_in,
	output logic clock_line_pin_out,
	output logic clock_line_pin_oe_n,
	input wire logic data_line_pin_in,
	output logic data_line_pin_out,
	output logic data_line_pin_oe_n,
	output logic core_wake,
	output logic core_irq
);
	typedef struct packed {
		logic [7:0] rdata;
		logic [1:0] ck_sync;
		logic [1:0] dt_sync;
		logic [7:0] tx_status_control;
		logic [7:0] rx_status_control;
		logic [7:0] pie;
		logic [7:0] core_irq_control;
		logic [7:0] div_lo;
		logic [7:0] div_hi;
		logic [7:0] baud;
		logic [8:0] hold;
		logic hold_full;
		logic tx_flag;
		logic [8:0] fifo0;
		logic [8:0] fifo1;
		logic [1:0] fifo_cnt;
		logic overrun;
		logic dat_out;
		logic dat_oe_n;
		logic wake;
		logic irq;
	} ssp_state_t;

	ssp_state_t s_q, s_d;
	ssp_pkg::ssp_bus_t bus;
	ssp_pkg::ssp_cfg_t cfg;
	logic sh_busy;
	logic sh_done;
	logic [8:0] sh_char;
	logic sh_dat;
	logic sh_clear;
	logic tx_mode;
	logic rx_mode;
	logic sh_load;

	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// ==========================================
	// configuration decode
	always_comb begin
		cfg.port_enable = s_q.rx_status_control[ssp_pkg::RX_PORT_ENABLE_BIT];
		cfg.sync_select = s_q.tx_status_control[ssp_pkg::TX_SYNC_BIT];
		cfg.clock_source_master_select = s_q.tx_status_control[ssp_pkg::TX_CLOCK_SOURCE_BIT];
		cfg.transmit_enable = s_q.tx_status_control[ssp_pkg::TX_ENABLE_BIT];
		cfg.transmit_nine_bit_select = s_q.tx_status_control[ssp_pkg::TX_NINE_BIT];
		cfg.receive_nine_bit_select = s_q.rx_status_control[ssp_pkg::RX_NINE_BIT];
		cfg.continuous_receive_enable = s_q.rx_status_control[ssp_pkg::RX_CONT_BIT];
		cfg.single_receive_enable = s_q.rx_status_control[ssp_pkg::RX_SINGLE_BIT];
	end

	// port live only as synchronous slave
	function automatic logic slave_live(input ssp_pkg::ssp_cfg_t c);
		slave_live = c.port_enable && c.sync_select && !c.clock_source_master_select;
	endfunction

	// only continuous receive enable selects receive direction; either enable blocks transmit
	assign rx_mode = slave_live(cfg) && cfg.continuous_receive_enable && !s_q.overrun;
	assign tx_mode = slave_live(cfg) && !cfg.continuous_receive_enable && !cfg.single_receive_enable
		&& cfg.transmit_enable;
	assign sh_clear = !slave_live(cfg);
	// held word waits until transmit direction is live; a further write replaces it and port disable drops it
	assign sh_load = s_q.hold_full && !sh_busy && tx_mode;

	// ==========================================
	// link shifter
	ssp_shifter u_shift (
		.mclk(mclk),
		.reset_n(reset_n),
		.clear(sh_clear),
		.clk_sync(s_q.ck_sync[1]),
		.dat_sync(s_q.dt_sync[1]),
		.tx_mode(tx_mode),
		.rx_mode(rx_mode),
		.nine(tx_mode ? cfg.transmit_nine_bit_select : cfg.receive_nine_bit_select),
		.load(sh_load),
		.load_char(s_q.hold),
		.busy(sh_busy),
		.rx_done(sh_done),
		.rx_char(sh_char),
		.dat_out(sh_dat)
	);

	// ==========================================
	// next state
	always_comb begin
		logic pop;
		logic hold_wr;
		s_d = s_q;
		pop = 1'b0;
		hold_wr = bus.wr && bus.addr == ssp_pkg::OFF_TX_HOLDING_REGISTER;
		// input synchronisers
		s_d.ck_sync = {s_q.ck_sync[0], clock_line_pin_in};
		s_d.dt_sync = {s_q.dt_sync[0], data_line_pin_in};

		// register reads, data one cycle later
		s_d.rdata = ssp_pkg::BYTE_ZERO;
		if (bus.rd) begin
			unique case (bus.addr)
				ssp_pkg::OFF_TX_STATUS_CONTROL: s_d.rdata = {s_q.tx_status_control[7:2], !sh_busy, s_q.tx_status_control[0]};
				ssp_pkg::OFF_RX_STATUS_CONTROL: s_d.rdata = {s_q.rx_status_control[7:3], 1'b0, s_q.overrun,
					s_q.fifo0[8]};
				ssp_pkg::OFF_RX_DATA_BUFFER: begin
					s_d.rdata = s_q.fifo0[7:0];
					pop = s_q.fifo_cnt != 2'h0;
				end
				ssp_pkg::OFF_PERIPHERAL_IRQ_ENABLE_ONE: s_d.rdata = s_q.pie;
				ssp_pkg::OFF_PERIPHERAL_IRQ_FLAG_ONE: begin
					s_d.rdata[ssp_pkg::PI_RECEIVE_BIT] = s_q.fifo_cnt != 2'h0;
					s_d.rdata[ssp_pkg::PI_TRANSMIT_BIT] = s_q.tx_flag;
				end
				ssp_pkg::OFF_BAUD_DIVISOR_LOW: s_d.rdata = s_q.div_lo;
				ssp_pkg::OFF_BAUD_DIVISOR_HIGH: s_d.rdata = s_q.div_hi;
				ssp_pkg::OFF_BAUD_CONTROL_FIRST: begin
					s_d.rdata = s_q.baud;
					s_d.rdata[ssp_pkg::BAUD_RX_IDLE_BIT] = !rx_mode;
				end
				ssp_pkg::OFF_CORE_IRQ_CONTROL: s_d.rdata = s_q.core_irq_control;
				default: s_d.rdata = ssp_pkg::BYTE_ZERO;
			endcase
		end

		// register writes
		if (bus.wr) begin
			unique case (bus.addr)
				ssp_pkg::OFF_TX_STATUS_CONTROL: s_d.tx_status_control = {bus.wdata[7:2], 1'b0, bus.wdata[0]};
				ssp_pkg::OFF_RX_STATUS_CONTROL: s_d.rx_status_control = {bus.wdata[7:3], 3'h0};
				ssp_pkg::OFF_PERIPHERAL_IRQ_ENABLE_ONE: s_d.pie = bus.wdata;
				ssp_pkg::OFF_BAUD_DIVISOR_LOW: s_d.div_lo = bus.wdata;
				ssp_pkg::OFF_BAUD_DIVISOR_HIGH: s_d.div_hi = bus.wdata;
				ssp_pkg::OFF_BAUD_CONTROL_FIRST: s_d.baud = bus.wdata;
				ssp_pkg::OFF_CORE_IRQ_CONTROL: s_d.core_irq_control = bus.wdata;
				default: s_d.baud = s_q.baud;
			endcase
		end

		// holding register, ninth bit taken from tx status at write time
		if (sh_load) begin
			s_d.hold_full = 1'b0;
		end
		if (hold_wr) begin
			s_d.hold = {s_q.tx_status_control[ssp_pkg::TX_NINTH_DATA_BIT] & cfg.transmit_nine_bit_select,
				bus.wdata};
			s_d.hold_full = 1'b1;
		end

		// transmit flag tracks an empty holding register; write clears it
		s_d.tx_flag = !s_d.hold_full && !hold_wr;

		// receive buffer: pop then push, overrun on third character
		if (pop) begin
			s_d.fifo0 = s_q.fifo1;
			s_d.fifo_cnt = s_q.fifo_cnt - 2'h1;
		end
		if (sh_done) begin
			if (s_d.fifo_cnt == ssp_pkg::FIFO_DEPTH) begin
				s_d.overrun = 1'b1;
			end else if (s_d.fifo_cnt == 2'h1) begin
				s_d.fifo1 = sh_char;
				s_d.fifo_cnt = 2'h2;
			end else begin
				s_d.fifo0 = sh_char;
				s_d.fifo_cnt = 2'h1;
			end
		end

		// clearing continuous or port enable drops the overrun
		if (!s_d.rx_status_control[ssp_pkg::RX_CONT_BIT] || !s_d.rx_status_control[ssp_pkg::RX_PORT_ENABLE_BIT]) begin
			s_d.overrun = 1'b0;
		end
		// port disable empties the holding register and receive buffer and clears the transmit flag
		if (!s_d.rx_status_control[ssp_pkg::RX_PORT_ENABLE_BIT]) begin
			s_d.hold_full = 1'b0;
			s_d.fifo_cnt = 2'h0;
			s_d.fifo0 = ssp_pkg::CHAR_ZERO;
			s_d.fifo1 = ssp_pkg::CHAR_ZERO;
			s_d.tx_flag = 1'b0;
		end

		// data pin driven only while transmitting; clock pin never driven
		s_d.dat_out = sh_dat;
		s_d.dat_oe_n = !tx_mode;

		// wake and interrupt request
		s_d.wake = core_sleep && s_q.core_irq_control[ssp_pkg::CORE_PERIPH_BIT] &&
			((s_q.tx_flag && s_q.pie[ssp_pkg::PI_TRANSMIT_BIT]) ||
			(s_q.fifo_cnt != 2'h0 && s_q.pie[ssp_pkg::PI_RECEIVE_BIT]));
		s_d.irq = s_q.core_irq_control[ssp_pkg::CORE_GLOBAL_BIT] && s_q.core_irq_control[ssp_pkg::CORE_PERIPH_BIT] &&
			((s_q.tx_flag && s_q.pie[ssp_pkg::PI_TRANSMIT_BIT]) ||
			(s_q.fifo_cnt != 2'h0 && s_q.pie[ssp_pkg::PI_RECEIVE_BIT]));
	end

	// state register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.dat_oe_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops; clock pin outputs tied to constants
	assign reg_rdata = s_q.rdata;
	assign data_line_pin_out = s_q.dat_out;
	assign data_line_pin_oe_n = s_q.dat_oe_n;
	assign clock_line_pin_out = 1'b0;
	assign clock_line_pin_oe_n = 1'b1;
	assign core_wake = s_q.wake;
	assign core_irq = s_q.irq;
endmodule

// ==== rtl/ssp_shifter.sv ====
/*
 link side shifter: samples the external clock line, finds its edges, and
 shifts one bit per link clock cycle out of or into a 9-bit register.
 assumes the clock line and data line are already two-flop synchronised.
*/
`timescale 1ns/1ps
module ssp_shifter (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic clk_sync,
	input wire logic dat_sync,
	input wire logic tx_mode,
	input wire logic rx_mode,
	input wire logic nine,
	input wire logic load,
	input wire logic [8:0] load_char,
	output logic busy,
	output logic rx_done,
	output logic [8:0] rx_char,
	output logic dat_out
);
	typedef struct packed {
		logic clk_prev;
		logic busy;
		logic rx_done;
		logic [8:0] sh;
		logic [3:0] cnt;
		logic dat_out;
	} ssp_sh_state_t;

	ssp_sh_state_t s_q, s_d;

	// ==========================================
	// leading edge drives data, trailing edge samples it
	always_comb begin
		logic rise;
		logic fall;
		logic [3:0] width;
		rise = clk_sync & ~s_q.clk_prev;
		fall = ~clk_sync & s_q.clk_prev;
		width = nine ? ssp_pkg::BITS_NINE : ssp_pkg::BITS_EIGHT;
		s_d = s_q;
		s_d.clk_prev = clk_sync;
		s_d.rx_done = 1'b0;
		if (clear) begin
			s_d.busy = 1'b0;
			s_d.cnt = ssp_pkg::COUNT_ZERO;
		end else if (tx_mode) begin
			if (load && !s_q.busy) begin
				s_d.sh = load_char;
				s_d.busy = 1'b1;
				s_d.cnt = ssp_pkg::COUNT_ZERO;
			end else if (s_q.busy && rise) begin
				s_d.dat_out = s_q.sh[0];
				s_d.sh = {1'b0, s_q.sh[8:1]};
			end else if (s_q.busy && fall) begin
				s_d.cnt = s_q.cnt + 4'h1;
				if (s_q.cnt + 4'h1 == width) begin
					s_d.busy = 1'b0;
					s_d.cnt = ssp_pkg::COUNT_ZERO;
				end
			end
		end else if (rx_mode) begin
			if (fall) begin
				s_d.sh = nine ? {dat_sync, s_q.sh[8:1]} : {1'b0, dat_sync, s_q.sh[7:1]};
				s_d.cnt = s_q.cnt + 4'h1;
				s_d.busy = 1'b1;
				if (s_q.cnt + 4'h1 == width) begin
					s_d.rx_done = 1'b1;
					s_d.busy = 1'b0;
					s_d.cnt = ssp_pkg::COUNT_ZERO;
				end
			end
		end else begin
			// no direction selected: drop any partial character
			s_d.busy = 1'b0;
			s_d.cnt = ssp_pkg::COUNT_ZERO;
		end
	end

	// state register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = s_q.busy;
	assign rx_done = s_q.rx_done;
	assign rx_char = s_q.sh;
	assign dat_out = s_q.dat_out;
endmodule

// ==== verification/ssp_master_model.sv ====
/*
 behavioural external master: clocks frames only, sends and takes lsb first.
 assumes the bench resolves the data line from the slave's output enable.
*/
`timescale 1ns/1ps
module ssp_master_model (
	output logic link_clk,
	output logic link_dat,
	input wire logic line_dat
);
	// clock stands low between frames
	initial begin
		link_clk = 1'b0;
		link_dat = 1'b0;
	end
	// one frame of n bits; gap stretches the low phase
	task automatic frame(input int n, input logic [8:0] send, input int gap, output logic [8:0] got);
		got = 9'h000;
		for (int i = 0; i < n; i++) begin
			link_clk = 1'b1;
			link_dat = send[i];
			if (i > 0) got[i-1] = line_dat;
			#80 link_clk = 1'b0;
			#(80 + gap);
		end
		got[n-1] = line_dat;
		link_dat = ~link_dat; // left at the inverse of the last bit
	endtask
endmodule

// ==== verification/ssp_port_asserts.sv ====
/*
 concurrent checks on the slave port's pins and register port.
 assumes it is bound to ssp_port; control registers are shadowed from writes.
*/
`timescale 1ns/1ps
module ssp_port_asserts (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic core_sleep,
	input wire logic clock_line_pin_out,
	input wire logic clock_line_pin_oe_n,
	input wire logic data_line_pin_oe_n,
	input wire logic core_wake,
	input wire logic core_irq
);
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic [7:0] ie_q;
	logic [7:0] core_q;
	// ==========================================
	// shadow of the control registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			ie_q <= 8'h00;
			core_q <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == ssp_pkg::OFF_TX_STATUS_CONTROL) tx_q <= reg_wdata;
			if (reg_addr == ssp_pkg::OFF_RX_STATUS_CONTROL) rx_q <= reg_wdata;
			if (reg_addr == ssp_pkg::OFF_PERIPHERAL_IRQ_ENABLE_ONE) ie_q <= reg_wdata;
			if (reg_addr == ssp_pkg::OFF_CORE_IRQ_CONTROL) core_q <= reg_wdata;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ==========================================
	// pin drivers
	a_clk_not_driven: assert property (clock_line_pin_oe_n && !clock_line_pin_out)
		else $error("clock line driven");
	a_oe_slave_tx: assert property (!data_line_pin_oe_n |-> $past(tx_q[5] && !tx_q[7]) || $past(tx_q[5], 2))
		else $error("data driven outside slave transmit");
	a_oe_port_on: assert property (!data_line_pin_oe_n |-> $past(rx_q[7] && tx_q[4]) || $past(rx_q[7], 2))
		else $error("data driven with port off");
	a_oe_not_rx: assert property (!data_line_pin_oe_n |-> $past(rx_q[5:4] == 2'b00) || $past(rx_q[4], 2) == 1'b0)
		else $error("data driven in receive mode");
	// ==========================================
	// register port, wake and request
	a_rdata_after_rd: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
		else $error("read data without read");
	a_wake_in_sleep: assert property (core_wake |-> $past(core_sleep))
		else $error("wake while awake");
	a_wake_source: assert property (core_wake |-> $past(core_q[6] && ie_q[5:4] != 2'b00))
		else $error("wake without enables");
	a_irq_global: assert property (core_irq |-> $past(core_q[7]))
		else $error("request without global enable");
	a_irq_source: assert property (core_irq |-> $past(core_q[6] && ie_q[5:4] != 2'b00))
		else $error("request without enables");
	c_tx_active: cover property (!data_line_pin_oe_n);
	c_wake: cover property ($rose(core_wake));
	c_irq: cover property ($rose(core_irq));
endmodule

// ==== verification/test_ssp_port.sv ====
/*
 self-checking bench for the slave port: transmit, receive, sleep, overrun.
 assumes the ssp_pkg offsets and a 160 ns link clock from the master model.
*/
`timescale 1ns/1ps
module test_ssp_port;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic core_sleep = 1'b0;
	logic [7:0] reg_rdata;
	logic clk_out, clk_oe_n, dat_out, dat_oe_n, core_wake, core_irq, m_clk, m_dat, line;
	logic [7:0] d;
	logic [8:0] got;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	// the transmitting party owns the data line
	assign line = !dat_oe_n ? dat_out : m_dat;
	always #10 mclk = ~mclk;
	ssp_port DUT (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_sleep(core_sleep), .clock_line_pin_in(m_clk),
		.clock_line_pin_out(clk_out), .clock_line_pin_oe_n(clk_oe_n), .data_line_pin_in(line),
		.data_line_pin_out(dat_out), .data_line_pin_oe_n(dat_oe_n), .core_wake(core_wake), .core_irq(core_irq));
	ssp_master_model m (.link_clk(m_clk), .link_dat(m_dat), .line_dat(line));
	// ==========================================
	// shared tasks
	task automatic chk(input logic [8:0] s, input logic [8:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_regs;
		logic [3:0] adr[4] = '{4'h1, 4'h3, 4'h5, 4'hf}; // rx status, rx data, flags, unmapped
		wr(ssp_pkg::OFF_RX_DATA_BUFFER, 8'hff);
		foreach (adr[i]) begin
			rd(adr[i]);
			chk(9'(d), 9'h000);
		end
		rd(ssp_pkg::OFF_BAUD_CONTROL_FIRST);
		chk(9'(d), 9'h040);
	endtask
	task automatic t_tx;
		wr(ssp_pkg::OFF_CORE_IRQ_CONTROL, 8'hc0);
		wr(ssp_pkg::OFF_PERIPHERAL_IRQ_ENABLE_ONE, 8'h10);
		wr(ssp_pkg::OFF_RX_STATUS_CONTROL, 8'h80);
		wr(ssp_pkg::OFF_TX_STATUS_CONTROL, 8'h30);
		wr(ssp_pkg::OFF_TX_HOLDING_REGISTER, 8'ha5);
		wr(ssp_pkg::OFF_TX_HOLDING_REGISTER, 8'h3c);
		// sleep only after both words are written
		core_sleep <= 1'b1;
		repeat (4) @(posedge mclk);
		rd(ssp_pkg::OFF_PERIPHERAL_IRQ_FLAG_ONE);
		chk(9'(d), 9'h000);
		chk(9'(core_wake), 9'h000);
		m.frame(8, 9'h000, 0, got);
		chk(got, 9'h0a5);
		repeat (8) @(posedge mclk);
		chk(9'({core_wake, core_irq}), 9'h003);
		rd(ssp_pkg::OFF_PERIPHERAL_IRQ_FLAG_ONE);
		chk(9'(d), 9'h010);
		core_sleep <= 1'b0;
		m.frame(8, 9'h000, 200, got);
		chk(got, 9'h03c);
		repeat (8) @(posedge mclk);
		rd(ssp_pkg::OFF_PERIPHERAL_IRQ_FLAG_ONE);
		chk(9'(d), 9'h010);
		wr(ssp_pkg::OFF_TX_STATUS_CONTROL, 8'h71);
		wr(ssp_pkg::OFF_TX_HOLDING_REGISTER, 8'h5a);
		repeat (4) @(posedge mclk);
		m.frame(9, 9'h000, 0, got);
		chk(got, 9'h15a);
		rd(ssp_pkg::OFF_TX_STATUS_CONTROL);
		chk(9'(d), 9'h073);
		wr(ssp_pkg::OFF_CORE_IRQ_CONTROL, 8'h00);
		wr(ssp_pkg::OFF_TX_STATUS_CONTROL, 8'h30);
	endtask
	task automatic t_rx;
		wr(ssp_pkg::OFF_RX_STATUS_CONTROL, 8'ha0);
		repeat (4) @(posedge mclk);
		chk(9'(dat_oe_n), 9'h001);
		m.frame(8, 9'h0ff, 0, got);
		repeat (8) @(posedge mclk);
		rd(ssp_pkg::OFF_PERIPHERAL_IRQ_FLAG_ONE);
		chk(9'(d), 9'h010);
		wr(ssp_pkg::OFF_PERIPHERAL_IRQ_ENABLE_ONE, 8'h20);
		wr(ssp_pkg::OFF_CORE_IRQ_CONTROL, 8'h40);
		wr(ssp_pkg::OFF_RX_STATUS_CONTROL, 8'h90);
		rd(ssp_pkg::OFF_BAUD_CONTROL_FIRST);
		chk(9'(d), 9'h000);
		core_sleep <= 1'b1;
		m.frame(8, 9'h012, 0, got);
		repeat (8) @(posedge mclk);
		chk(9'({core_wake, core_irq}), 9'h002);
		core_sleep <= 1'b0;
		m.frame(8, 9'h034, 300, got);
		m.frame(8, 9'h056, 0, got);
		repeat (8) @(posedge mclk);
		rd(ssp_pkg::OFF_RX_STATUS_CONTROL);
		chk(9'(d), 9'h092);
		rd(ssp_pkg::OFF_RX_DATA_BUFFER);
		chk(9'(d), 9'h012);
		rd(ssp_pkg::OFF_PERIPHERAL_IRQ_FLAG_ONE);
		chk(9'(d), 9'h030);
		rd(ssp_pkg::OFF_RX_DATA_BUFFER);
		chk(9'(d), 9'h034);
		rd(ssp_pkg::OFF_PERIPHERAL_IRQ_FLAG_ONE);
		chk(9'(d), 9'h010);
		wr(ssp_pkg::OFF_RX_STATUS_CONTROL, 8'h80);
		rd(ssp_pkg::OFF_RX_STATUS_CONTROL);
		chk(9'(d), 9'h080);
		// nine-bit character, ninth bit read from status first
		wr(ssp_pkg::OFF_RX_STATUS_CONTROL, 8'hd0);
		m.frame(9, 9'h1a5, 0, got);
		repeat (8) @(posedge mclk);
		rd(ssp_pkg::OFF_RX_STATUS_CONTROL);
		chk(9'(d), 9'h0d1);
		rd(ssp_pkg::OFF_RX_DATA_BUFFER);
		chk(9'(d), 9'h0a5);
	endtask
	// ==========================================
	// hang guard
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			tally_and_finish;
		end
	end
	// main sequence
	initial begin
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		t_regs;
		t_tx;
		t_rx;
		tally_and_finish;
	end
endmodule
bind ssp_port ssp_port_asserts chk_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_sleep(core_sleep),
	.clock_line_pin_out(clock_line_pin_out), .clock_line_pin_oe_n(clock_line_pin_oe_n),
	.data_line_pin_oe_n(data_line_pin_oe_n), .core_wake(core_wake), .core_irq(core_irq));
